/* File: design/burner_sequencer.sv */
// Purpose: Ignition trial, run and post-purge sequencing for one burner.
// Assumes: Inputs synchronous to ref_clk; timing in whole one-second ticks.
// Notes:   Software starts a cycle via the control register run bit.
//
// Summary of operation
// [R1] Valve proving runs direct spark unless jumper removed.
// [R2] Plain demand: pilot, ignition, second valve on.
// [R3] Plain demand: second valve pilot lasts 15 s.
// [R4] Pilot/ignition output interrupted after ten seconds.
// [R5] Low-fire switch opening in pilot trips shutdown.
// [R6] Pre-ignition interlock ignored during ignition trial.
// [R7] Flame proven by 10 s, 4 s short.
// [R8] Ignition output off five seconds into pilot.
// [R9] Flame proven: first valve on, second if proving.
// [R10] Pilot/ignition off 10 s after first valve.
// [R11] No proving: second valve off after 15 s.
// [R12] Direct spark: ignition and both valves together.
// [R13] Direct spark: flame at 4 s, else lockout.
// [R14] Proving without direct spark: main period 10 s.
// [R15] Run holds ten seconds, then releases modulation.
// [R16] Run lasts until active demand opens.
// [R17] Blower held for programmable post-purge time.
// [R18] Post-purge start: valves off, motor to low.
// [R19] Interlock must close five seconds after demand.
// [R20] Proving test during post-purge, then finish time.
// [R21] Trial waits for low-fire switch at low fire.
// [R22] One-second tick; reset idles all outputs off.
`timescale 1ns/1ps
module burner_sequencer #(
  parameter int unsigned TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        demand_plain,
  input  wire logic        demand_proving,
  input  wire logic        flame_proven,
  input  wire logic        low_fire_switch,
  input  wire logic        preign_interlock,
  input  wire logic        short_trial_jumper,
  input  wire logic        spark_direct_jumper,
  input  wire logic        proving_test_done,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             pilot_ign_out,
  output logic             ignition_out,
  output logic             first_main_valve,
  output logic             second_main_valve,
  output logic             blower_out,
  output logic             motor_low_fire,
  output logic             motor_modulate,
  output logic             proving_test_req,
  output logic             safety_shutdown,
  output logic             lockout
);
  import seq_pkg::*;

  // ----------
  // Register file and timebase
  // ----------
  logic [2:0]       ctrl_reg;
  logic [SEC_W-1:0] post_reg;
  logic [31:0]      status;
  logic             tick;
  logic             restart;
  phase_e           phase_reg;
  phase_e           phase_next;
  logic [SEC_W-1:0] secs_reg;
  logic [SEC_W-1:0] pii_secs_reg;
  logic             proving_done_reg;
  logic             pii_fault_reg;

  axil_regs u_regs (
    .ref_clk,
    .rst_n,
    .awaddr,
    .awvalid,
    .awready,
    .wdata,
    .wstrb,
    .wvalid,
    .wready,
    .bresp,
    .bvalid,
    .bready,
    .araddr,
    .arvalid,
    .arready,
    .rdata,
    .rresp,
    .rvalid,
    .rready,
    .status,
    .ctrl_reg,
    .post_reg
  );

  sec_tick #(.CYCLES(TICK_CYCLES)) u_tick ( // R22
    .ref_clk,
    .rst_n,
    .restart,
    .tick
  );

  // ----------
  // Mode decode
  // ----------
  logic vp_mode;
  logic dsi_mode;
  logic demand;
  logic [SEC_W-1:0] pilot_len;
  logic [SEC_W-1:0] main_len;

  assign vp_mode   = ctrl_reg[CTRL_VP_BIT];
  assign dsi_mode  = vp_mode && spark_direct_jumper; // R1
  assign demand    = vp_mode ? demand_proving : demand_plain; // R16
  assign pilot_len = short_trial_jumper ? PILOT_SHORT_S : PILOT_LONG_S; // R7
  assign main_len  = vp_mode ? MAIN_VP_S : MAIN_PLAIN_S; // R14
  assign restart   = (phase_next != phase_reg);
  assign status    = {16'h0, 4'(phase_reg), 6'h0, pii_fault_reg, flame_proven,
                      low_fire_switch, lockout, safety_shutdown, first_main_valve};

  function automatic logic reached(input logic [SEC_W-1:0] secs, input logic [SEC_W-1:0] limit, input logic t);
    reached = t && (secs + 12'd1 >= limit);
  endfunction : reached

  // ----------
  // Phase sequencing
  // ----------
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      ST_IDLE:
        if (ctrl_reg[CTRL_RUN_BIT] && demand) phase_next = ST_WAIT_LOW_FIRE;
      ST_WAIT_LOW_FIRE: begin
        if (!demand) phase_next = ST_IDLE;
        else if (low_fire_switch) phase_next = dsi_mode ? ST_DSI_MAIN : ST_PILOT; // R21 R1
      end
      ST_PILOT: begin
        if (!low_fire_switch) phase_next = ST_SHUTDOWN; // R5
        else if (reached(secs_reg, pilot_len, tick))
          phase_next = flame_proven ? ST_MAIN : ST_SHUTDOWN; // R7
      end
      ST_MAIN: begin
        if (!flame_proven) phase_next = ST_SHUTDOWN;
        else if (reached(secs_reg, main_len, tick)) phase_next = ST_RUN;
      end
      ST_DSI_MAIN:
        if (reached(secs_reg, DSI_MAIN_S, tick))
          phase_next = flame_proven ? ST_RUN : ST_LOCKOUT; // R13
      ST_RUN: begin
        if (!flame_proven) phase_next = ST_SHUTDOWN;
        else if (!demand) phase_next = ST_POSTPURGE; // R16
      end
      ST_POSTPURGE: // R20
        if (secs_reg >= post_reg && (proving_done_reg || !ctrl_reg[CTRL_AFTER_BIT] || !vp_mode))
          phase_next = ST_IDLE;
      ST_SHUTDOWN:
        if (!ctrl_reg[CTRL_RUN_BIT]) phase_next = ST_IDLE;
      ST_LOCKOUT:
        phase_next = ST_LOCKOUT;
      default: phase_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) phase_reg <= ST_IDLE; // R22
    else phase_reg <= phase_next;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) secs_reg <= 12'd0;
    else if (restart) secs_reg <= 12'd0;
    else if (tick && secs_reg != POST_MAX_S) secs_reg <= secs_reg + 12'd1;
  end

  // Interlock watch after demand opens; the ignition trial never looks at it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pii_secs_reg  <= 12'd0;
      pii_fault_reg <= 1'b0;
    end else if (phase_reg == ST_POSTPURGE) begin
      if (tick && pii_secs_reg != PII_WAIT_S) pii_secs_reg <= pii_secs_reg + 12'd1;
      if (pii_secs_reg == PII_WAIT_S && !preign_interlock) pii_fault_reg <= 1'b1; // R19
    end else begin
      pii_secs_reg <= 12'd0; // R6
      if (phase_reg == ST_WAIT_LOW_FIRE) pii_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) proving_done_reg <= 1'b0;
    else if (phase_reg != ST_POSTPURGE) proving_done_reg <= 1'b0;
    else if (proving_test_done) proving_done_reg <= 1'b1; // R20
  end

  // ----------
  // Output drives
  // ----------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin // R22
      pilot_ign_out     <= 1'b0;
      ignition_out      <= 1'b0;
      first_main_valve  <= 1'b0;
      second_main_valve <= 1'b0;
      blower_out        <= 1'b0;
      motor_low_fire    <= 1'b0;
      motor_modulate    <= 1'b0;
      proving_test_req  <= 1'b0;
      safety_shutdown   <= 1'b0;
      lockout           <= 1'b0;
    end else begin
      pilot_ign_out     <= 1'b0;
      ignition_out      <= 1'b0;
      first_main_valve  <= 1'b0;
      second_main_valve <= 1'b0;
      blower_out        <= 1'b0;
      motor_low_fire    <= 1'b0;
      motor_modulate    <= 1'b0;
      proving_test_req  <= 1'b0;
      safety_shutdown   <= 1'b0;
      lockout           <= 1'b0;
      unique case (phase_next)
        ST_IDLE: ;
        ST_WAIT_LOW_FIRE: begin
          blower_out     <= 1'b1;
          motor_low_fire <= 1'b1;
        end
        ST_PILOT: begin
          blower_out        <= 1'b1;
          motor_low_fire    <= 1'b1;
          pilot_ign_out     <= 1'b1; // R2 R4
          ignition_out      <= (phase_reg != ST_PILOT) || (secs_reg < SPARK_END_S); // R2 R8
          second_main_valve <= 1'b1; // R2 R3
        end
        ST_MAIN: begin
          blower_out        <= 1'b1;
          motor_low_fire    <= 1'b1;
          first_main_valve  <= 1'b1; // R9
          pilot_ign_out     <= (phase_reg != ST_MAIN) || (secs_reg < PILOT_OFF_S); // R10
          second_main_valve <= vp_mode || (phase_reg != ST_MAIN) || (secs_reg < MV2_PILOT_S); // R9 R11 R3
        end
        ST_DSI_MAIN: begin
          blower_out        <= 1'b1;
          motor_low_fire    <= 1'b1;
          ignition_out      <= 1'b1; // R12
          first_main_valve  <= 1'b1; // R12
          second_main_valve <= 1'b1; // R12
        end
        ST_RUN: begin
          blower_out        <= 1'b1;
          first_main_valve  <= 1'b1;
          second_main_valve <= vp_mode || (phase_reg == ST_MAIN && secs_reg < MV2_PILOT_S);
          motor_low_fire    <= (phase_reg != ST_RUN) || (secs_reg < STAB_S); // R15
          motor_modulate    <= (phase_reg == ST_RUN) && (secs_reg >= STAB_S); // R15
        end
        ST_POSTPURGE: begin
          blower_out       <= 1'b1; // R17
          motor_low_fire   <= 1'b1; // R18
          proving_test_req <= vp_mode && ctrl_reg[CTRL_AFTER_BIT] && !proving_done_reg; // R20
        end
        ST_SHUTDOWN: safety_shutdown <= 1'b1;
        ST_LOCKOUT:  lockout <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule : burner_sequencer

/* File: design/seq_pkg.sv */
// Purpose: Shared constants for the ignition, run and post-purge sequencer.
// Assumes: 10 MHz reference clock; all phase timing counted in whole seconds.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package seq_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned TICK_PERIOD_S     = 1;
  localparam int unsigned TICK_CYCLES       = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned SEC_W             = 12;
  localparam logic [SEC_W-1:0] PILOT_LONG_S   = 12'd10;
  localparam logic [SEC_W-1:0] PILOT_SHORT_S  = 12'd4;
  localparam logic [SEC_W-1:0] SPARK_END_S    = 12'd5;
  localparam logic [SEC_W-1:0] PILOT_OFF_S    = 12'd10;
  localparam logic [SEC_W-1:0] MV2_PILOT_S    = 12'd15;
  localparam logic [SEC_W-1:0] MAIN_VP_S      = 12'd10;
  localparam logic [SEC_W-1:0] MAIN_PLAIN_S   = 12'd15;
  localparam logic [SEC_W-1:0] DSI_MAIN_S     = 12'd4;
  localparam logic [SEC_W-1:0] STAB_S         = 12'd10;
  localparam logic [SEC_W-1:0] PII_WAIT_S     = 12'd5;
  localparam logic [SEC_W-1:0] POST_DEF_S     = 12'd15;
  localparam logic [SEC_W-1:0] POST_MAX_S     = 12'd3960;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  POST_OFFSET   = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h08;
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_VP_BIT     = 1;
  localparam int unsigned CTRL_AFTER_BIT  = 2;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_LOW_FIRE, ST_PILOT, ST_MAIN, ST_DSI_MAIN, ST_RUN,
    ST_POSTPURGE, ST_SHUTDOWN, ST_LOCKOUT
  } phase_e;
endpackage : seq_pkg

/* File: design/sec_tick.sv */
// Purpose: One-second enable pulse derived from the reference clock.
// Assumes: Single clock domain.
// Notes:   Divider length is a parameter so simulation can shorten it.
`timescale 1ns/1ps
module sec_tick #(
  parameter int unsigned CYCLES = seq_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  import seq_pkg::*;
  logic [31:0] count_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 32'h0;
      tick      <= 1'b0;
    end else if (restart || count_reg == CYCLES - 1) begin
      count_reg <= 32'h0;
      tick      <= !restart;
    end else begin
      count_reg <= count_reg + 32'h1;
      tick      <= 1'b0;
    end
  end
endmodule : sec_tick

/* File: design/axil_regs.sv */
// Purpose: AXI4-Lite slave holding control, post-purge time and status words.
// Assumes: One write and one read outstanding; writes answer one cycle after capture, reads on the capture edge.
// Notes:   Unmapped addresses answer SLVERR; reads of them return zero.
`timescale 1ns/1ps
module axil_regs (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [31:0]          status,
  output logic [2:0]                ctrl_reg,
  output logic [seq_pkg::SEC_W-1:0] post_reg
);
  import seq_pkg::*;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        have_aw_reg;
  logic        have_w_reg;
  logic [31:0] merged;

  always_comb begin
    merged = 32'h0;
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : 8'h00;
    end
  end

  // Address and data are accepted independently, in either order.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      have_aw_reg <= 1'b0;
      have_w_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      ctrl_reg    <= 3'h0;
      post_reg    <= POST_DEF_S;
    end else begin
      if (awvalid && awready) begin
        aw_addr_reg <= awaddr;
        have_aw_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        have_w_reg <= 1'b1;
        wready     <= 1'b0;
      end
      if (have_aw_reg && have_w_reg && !bvalid) begin
        bvalid <= 1'b1;
        bresp  <= RESP_OKAY;
        unique case (aw_addr_reg)
          CTRL_OFFSET: ctrl_reg <= merged[2:0];
          POST_OFFSET: begin
            // The low 12 bits of the post-purge time saturate at its documented maximum; higher bits are dropped.
            if (merged[SEC_W-1:0] > POST_MAX_S) post_reg <= POST_MAX_S; // R17
            else post_reg <= merged[SEC_W-1:0]; // R17
          end
          STATUS_OFFSET: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid      <= 1'b0;
        have_aw_reg <= 1'b0;
        have_w_reg  <= 1'b0;
        awready     <= 1'b1;
        wready      <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= RESP_OKAY;
      unique case (araddr)
        CTRL_OFFSET:   rdata <= {29'h0, ctrl_reg};
        POST_OFFSET:   rdata <= {{(32-SEC_W){1'b0}}, post_reg};
        STATUS_OFFSET: rdata <= status;
        default: begin
          rdata <= 32'h0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : axil_regs

/* File: sim/burner_sequencer_asserts.sv */
// Purpose: Timing and safety checks on the sequencer outputs.
// Assumes: One clock, async active-low reset.
// Notes:   Phase times are judged within one tick of slack.
`timescale 1ns/1ps
module burner_sequencer_asserts #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flame_proven,
  input wire logic low_fire_switch,
  input wire logic pilot_ign_out,
  input wire logic ignition_out,
  input wire logic first_main_valve,
  input wire logic second_main_valve,
  input wire logic blower_out,
  input wire logic motor_low_fire,
  input wire logic motor_modulate,
  input wire logic safety_shutdown,
  input wire logic lockout
);
  localparam logic [31:0] T = TICK_CYCLES;
  logic [31:0] ign_cnt_reg;
  logic [31:0] mv1_cnt_reg;
  logic        trip;
  assign trip = safety_shutdown | lockout;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Cycles the spark and first valve have been on.
  // ----------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ign_cnt_reg <= '0;
      mv1_cnt_reg <= '0;
    end else begin
      ign_cnt_reg <= ignition_out ? ign_cnt_reg + 32'h1 : 32'h0;
      mv1_cnt_reg <= first_main_valve ? mv1_cnt_reg + 32'h1 : 32'h0;
    end
  end
  spark_stop_a: assert property ($fell(ignition_out) && !first_main_valve && !trip |->
    ign_cnt_reg >= 4 * T && ign_cnt_reg <= 6 * T) else $error("pilot spark time wrong");
  dsi_spark_a: assert property ($fell(ignition_out) && first_main_valve |->
    ign_cnt_reg >= 3 * T && ign_cnt_reg <= 5 * T) else $error("main spark time wrong");
  pilot_off_a: assert property ($fell(pilot_ign_out) && first_main_valve |->
    mv1_cnt_reg >= 9 * T && mv1_cnt_reg <= 11 * T) else $error("pilot off time wrong");
  mv2_off_a: assert property ($fell(second_main_valve) && first_main_valve |->
    mv1_cnt_reg >= 14 * T && mv1_cnt_reg <= 16 * T) else $error("second valve off time wrong");
  modulate_a: assert property ($rose(motor_modulate) |-> first_main_valve &&
    mv1_cnt_reg >= 13 * T && mv1_cnt_reg <= 26 * T) else $error("modulation release wrong");
  pilot_start_a: assert property ($rose(pilot_ign_out) |->
    ignition_out && second_main_valve && !first_main_valve) else $error("pilot start outputs wrong");
  lowfire_trip_a: assert property (pilot_ign_out && !first_main_valve && !low_fire_switch |->
    ##[1:3] safety_shutdown) else $error("no trip on low fire open");
  flame_gate_a: assert property ($rose(first_main_valve) && pilot_ign_out |->
    $past(flame_proven) && second_main_valve) else $error("valve opened without flame");
  dsi_together_a: assert property ($rose(first_main_valve) && !pilot_ign_out |->
    ignition_out && second_main_valve) else $error("direct spark outputs not together");
  post_start_a: assert property ($fell(first_main_valve) && !trip |->
    !second_main_valve && motor_low_fire && blower_out) else $error("post-purge start wrong");
  trip_safe_a: assert property (trip |->
    !first_main_valve && !second_main_valve && !pilot_ign_out && !ignition_out) else $error("fuel on in trip");
  cover property ($rose(motor_modulate));
  cover property ($rose(safety_shutdown));
  cover property ($rose(lockout));
endmodule : burner_sequencer_asserts

bind burner_sequencer burner_sequencer_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .ref_clk, .rst_n, .flame_proven, .low_fire_switch, .pilot_ign_out, .ignition_out, .first_main_valve,
  .second_main_valve, .blower_out, .motor_low_fire, .motor_modulate, .safety_shutdown, .lockout);

/* File: sim/burner_plant.sv */
// Purpose: Behavioural burner plant: motor, flame, valve closure, tester.
// Assumes: Same clock as the sequencer.
// Notes:   Flame and low-fire faults appear only when the bench asks.
`timescale 1ns/1ps
module burner_plant (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic pilot_ign_out,
  input  wire logic first_main_valve,
  input  wire logic second_main_valve,
  input  wire logic motor_low_fire,
  input  wire logic motor_modulate,
  input  wire logic proving_test_req,
  input  wire logic flame_ok,
  input  wire logic lfs_open,
  output logic      flame_proven,
  output logic      low_fire_switch,
  output logic      preign_interlock,
  output logic      proving_test_done
);
  logic [2:0] motor_reg;
  logic       at_low_reg;
  logic [1:0] fuel_reg;
  logic [2:0] shut_reg;
  logic [4:0] test_reg;
  logic       fuel;
  assign fuel = pilot_ign_out | first_main_valve | second_main_valve;
  // ----------
  // Motor travel, flame build-up and valve closure take a few cycles.
  // ----------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_reg <= '0;
      at_low_reg <= 1'b0;
      fuel_reg <= '0;
      shut_reg <= '0;
      test_reg <= '0;
    end else begin
      motor_reg <= {motor_reg[1:0], motor_low_fire};
      at_low_reg <= motor_modulate ? 1'b0 : (&motor_reg | at_low_reg);
      fuel_reg <= {fuel_reg[0], fuel};
      shut_reg <= {shut_reg[1:0], ~fuel};
      if (!proving_test_req) test_reg <= 5'h0;
      else if (test_reg != 5'h14) test_reg <= test_reg + 5'h1;
    end
  end
  assign low_fire_switch   = at_low_reg & ~lfs_open;
  assign flame_proven      = flame_ok & (&fuel_reg);
  assign preign_interlock  = &shut_reg;
  assign proving_test_done = test_reg == 5'h14;
endmodule : burner_plant

/* File: sim/burner_sequencer_tb.sv */
// Purpose: Self-checking bench for the burner sequencer.
// Assumes: Tick shortened to 10 clocks; the plant model closes the loop.
// Notes:   Bus answers are checked from a queue of expected results.
`timescale 1ns/1ps
module burner_sequencer_tb;
  import seq_pkg::*;
  localparam int TC = 10;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  typedef struct packed {logic [31:0] m; logic [33:0] v;} exp_s;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        demand_plain = 1'b0, demand_proving = 1'b0, flame_ok = 1'b1, lfs_open = 1'b0;
  logic        short_trial_jumper = 1'b0, spark_direct_jumper = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, pilot_ign_out, ignition_out, blower_out;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        first_main_valve, second_main_valve, motor_low_fire, motor_modulate, lockout;
  logic        proving_test_req, safety_shutdown, flame_proven, low_fire_switch;
  logic        preign_interlock, proving_test_done;
  logic [8:0]  outs;
  exp_s        q[$];
  exp_s        e;
  int          n_fail = 0, check_count = 0, n, post_s;
  assign outs = {lockout, safety_shutdown, proving_test_req, blower_out, motor_modulate,
                 second_main_valve, first_main_valve, ignition_out, pilot_ign_out};
  always #50 ref_clk = ~ref_clk;
  burner_sequencer #(.TICK_CYCLES(TC)) dut_u (.ref_clk, .rst_n, .demand_plain, .demand_proving,
    .flame_proven, .low_fire_switch, .preign_interlock, .short_trial_jumper, .spark_direct_jumper,
    .proving_test_done, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pilot_ign_out, .ignition_out,
    .first_main_valve, .second_main_valve, .blower_out, .motor_low_fire, .motor_modulate,
    .proving_test_req, .safety_shutdown, .lockout);
  burner_plant plant_u (.ref_clk, .rst_n, .pilot_ign_out, .first_main_valve, .second_main_valve,
    .motor_low_fire, .motor_modulate, .proving_test_req, .flame_ok, .lfs_open, .flame_proven,
    .low_fire_switch, .preign_interlock, .proving_test_done);
  // ----------
  // Checking, bus and wait tasks.
  // ----------
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wn(input int i, input logic v, input int s);
    wt(i, v, n);
    chk({33'h0, n >= (s - 1) * TC && n <= (s + 1) * TC + 4}, 34'h1);
  endtask : wn
  task wt(input int i, input logic v, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (outs[i] !== v);
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({32'h0, r, 32'h0});
    @(posedge ref_clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge ref_clk);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    q.push_back({m, r, d});
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk);
    rready <= 1'b0;
  endtask : rd
  task results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  always @(posedge ref_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      chk(bvalid ? {bresp, 32'h0} : {rresp, rdata & e.m}, {e.v[33:32], e.v[31:0] & e.m});
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    results();
  end
  // ----------
  // Scenarios.
  // ----------
  initial begin
    post_s = $urandom(15);
    post_s = 2 + $urandom_range(3);
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(CTRL_OFFSET, 32'h0, ALL, RESP_OKAY);
    rd(POST_OFFSET, {20'h0, POST_DEF_S}, ALL, RESP_OKAY);
    rd(8'h0C, 32'h0, ALL, RESP_SLVERR);
    wr(8'h0C, 32'h5, RESP_SLVERR);
    wr(POST_OFFSET, 32'hFFFF, RESP_OKAY);
    rd(POST_OFFSET, {20'h0, POST_MAX_S}, ALL, RESP_OKAY);
    wr(POST_OFFSET, 32'(post_s), RESP_OKAY);
    demand_plain <= 1'b1;
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    wt(0, 1'b1, n);
    wn(1, 1'b0, 5);
    wn(2, 1'b1, 5);
    chk({33'h0, second_main_valve & ~safety_shutdown}, 34'h1);
    wn(0, 1'b0, 10);
    wn(3, 1'b0, 5);
    wn(4, 1'b1, 10);
    repeat (20 * TC) @(posedge ref_clk);
    chk({33'h0, first_main_valve}, 34'h1);
    demand_plain <= 1'b0;
    wt(2, 1'b0, n);
    chk({32'h0, blower_out, motor_low_fire}, 34'h3);
    wn(5, 1'b0, post_s);
    short_trial_jumper <= 1'b1;
    flame_ok <= 1'b0;
    demand_plain <= 1'b1;
    wt(0, 1'b1, n);
    wn(7, 1'b1, 4);
    rd(STATUS_OFFSET, 32'h2, 32'h7, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    {short_trial_jumper, flame_ok} <= 2'h1;
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    wt(0, 1'b1, n);
    repeat (2 * TC) @(posedge ref_clk);
    lfs_open <= 1'b1;
    wt(7, 1'b1, n);
    chk({33'h0, n <= 4}, 34'h1);
    {lfs_open, demand_plain, demand_proving, spark_direct_jumper} <= 4'h3;
    wr(CTRL_OFFSET, 32'h0, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h7, RESP_OKAY);
    wt(2, 1'b1, n);
    chk({33'h0, pilot_ign_out}, 34'h0);
    chk({32'h0, ignition_out, second_main_valve}, 34'h3);
    wn(1, 1'b0, 4);
    wn(4, 1'b1, 10);
    demand_proving <= 1'b0;
    wt(6, 1'b1, n);
    chk({32'h0, first_main_valve, second_main_valve}, 34'h0);
    wt(5, 1'b0, n);
    {spark_direct_jumper, demand_proving} <= 2'h1;
    wr(CTRL_OFFSET, 32'h3, RESP_OKAY);
    wt(0, 1'b1, n);
    wn(2, 1'b1, 10);
    chk({33'h0, second_main_valve}, 34'h1);
    wn(4, 1'b1, 20);
    demand_proving <= 1'b0;
    wt(5, 1'b0, n);
    {flame_ok, spark_direct_jumper, demand_proving} <= 3'h3;
    wt(8, 1'b1, n);
    rd(STATUS_OFFSET, 32'h4, 32'h7, RESP_OKAY);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({32'h0, lockout, blower_out}, 34'h0);
    results();
  end
endmodule : burner_sequencer_tb
